// ### logic/otl_params.svh
// constants of the overtravel and torque-limit block
//
// Functional notes
// - direction select 0 means CCW forward, 1 CW
// - forward input low allows, high prohibits forward
// - reverse input low allows, high prohibits reverse
// - forward map 2 uses input, 8 ignores it
// - reverse map 3 uses input, 8 ignores it
// - stop mode 0 stops as servo off
// - stop mode 1 decelerates, then zero clamp
// - stop mode 2 decelerates, then coasts
// - torque control follows servo-off stop, then coasts
// - emergency stop torque, default 800, modes 1/2
// - separate forward and reverse caps, 0 to 800
// - cap above motor maximum uses motor maximum
// - flag limit reached on output and monitor
// - drive limit output only when assigned terminal
// - set above limit, clear below limit
// - select 0 none, 1..3 terminal one..three
`ifndef OTL_PARAMS_SVH
`define OTL_PARAMS_SVH

`define OTL_TRQ_W 12
`define OTL_IRQ_W 4
`define OTL_TERM_N 3

`define OTL_A_CTRL 8'h00
`define OTL_A_FWD_CAP 8'h04
`define OTL_A_REV_CAP 8'h08
`define OTL_A_ESTOP 8'h0C
`define OTL_A_MAX_TRQ 8'h10
`define OTL_A_MONITOR 8'h14
`define OTL_A_IRQ_STAT 8'h18
`define OTL_A_IRQ_MASK 8'h1C

`define OTL_CTRL_RST 16'h0C80
`define OTL_TRQ_RST 12'h320
`define OTL_TRQ_MAX 12'h320
`define OTL_MAX_TRQ_RST 12'h12C
`define OTL_IRQ_MASK_RST 4'h0

`define OTL_MAP_IGNORE 4'h8
`define OTL_OT_SOFF 2'h0
`define OTL_OT_ZCLAMP 2'h1
`define OTL_OT_COAST 2'h2

`define OTL_IRQ_FWD_HIT 0
`define OTL_IRQ_REV_HIT 1
`define OTL_IRQ_CLT 2
`define OTL_IRQ_STOPPED 3

`endif

// ### logic/otl_pkg.sv
// types and shared helpers of the overtravel and torque-limit block
`include "otl_params.svh"
package otl_pkg;

  typedef struct packed {
    logic [1:0] clt_sel;
    logic [3:0] rev_map;
    logic [3:0] fwd_map;
    logic trq_ctrl;
    logic [1:0] soff_mode;
    logic [1:0] ot_mode;
    logic dir_sel;
  } otl_ctrl_t;

  typedef enum logic [2:0] {ST_RUN, ST_SOFF, ST_DECEL, ST_ZCLAMP, ST_COAST} otl_stop_t;

  typedef struct packed {
    otl_ctrl_t ctrl;
    logic [`OTL_TRQ_W-1:0] fwd_cap;
    logic [`OTL_TRQ_W-1:0] rev_cap;
    logic [`OTL_TRQ_W-1:0] estop_trq;
    logic [`OTL_TRQ_W-1:0] max_trq;
    logic [`OTL_IRQ_W-1:0] irq_stat;
    logic [`OTL_IRQ_W-1:0] irq_mask;
    otl_stop_t st;
    logic stop_fwd;
    logic fwd_ok;
    logic rev_ok;
    logic clt;
    logic signed [`OTL_TRQ_W-1:0] trq;
    logic [`OTL_TERM_N-1:0] term;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } otl_state_t;

  // smaller of a setting and a ceiling
  function automatic logic [`OTL_TRQ_W-1:0] eff_limit(input logic [`OTL_TRQ_W-1:0] cap,
                                                        input logic [`OTL_TRQ_W-1:0] ceil);
    eff_limit = (cap > ceil) ? ceil : cap;
  endfunction : eff_limit

endpackage : otl_pkg

// ### logic/otl_top.sv
// overtravel gating, overtravel stop sequence and internal torque limits
`timescale 1ns/1ns
`include "otl_params.svh"
module otl_top (
  input wire logic pclk, // bus and control clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic fwd_travel_ok_in, // forward overtravel, low allows
  input wire logic rev_travel_ok_in, // reverse overtravel, low allows
  input wire logic signed [`OTL_TRQ_W-1:0] torque_ref_in, // logical torque ref, % rated
  input wire logic motor_moving_in, // motor not yet at standstill
  input wire logic motor_ccw_in, // rotation is ccw seen from load
  output logic signed [`OTL_TRQ_W-1:0] motor_torque, // torque, positive is ccw
  output logic servo_off_stop, // stop as at servo off
  output logic [1:0] servo_off_mode, // servo-off stop mode to apply
  output logic zero_clamp, // hold in zero clamp
  output logic coast, // motor left coasting
  output logic [2:0] drive_state, // stop sequence state
  output logic torque_limited_out, // torque limit reached
  output logic output_terminal_1, // first output terminal, high is on
  output logic output_terminal_2, // second output terminal, high is on
  output logic output_terminal_3, // third output terminal, high is on
  output logic irq // level interrupt
);

  otl_pkg::otl_state_t q;
  otl_pkg::otl_state_t d;

  logic fwd_ot;
  logic rev_ot;
  logic mov_fwd;
  logic hit_f;
  logic hit_r;
  logic stop_ot;
  logic ref_away;
  logic acc;
  logic wr;
  logic stopped_ev;
  logic [`OTL_IRQ_W-1:0] ev;
  logic [`OTL_IRQ_W-1:0] clr;
  logic signed [`OTL_TRQ_W-1:0] trq_lim;
  logic signed [`OTL_TRQ_W-1:0] trq_log;
  logic signed [`OTL_TRQ_W-1:0] estop_mag;
  logic clt_next;
  logic [`OTL_TRQ_W-1:0] wval;
  logic [$bits(otl_pkg::otl_ctrl_t)-1:0] cval;

  otl_torque_clamp u_clamp (
    .torque_ref(torque_ref_in),
    .fwd_cap(q.fwd_cap),
    .rev_cap(q.rev_cap),
    .max_trq(q.max_trq),
    .fwd_block(fwd_ot),
    .rev_block(rev_ot),
    .clt_now(q.clt),
    .torque_lim(trq_lim),
    .clt_next(clt_next)
  );

  always_comb
  begin
    d = q;
    ev = '0;
    clr = '0;
    stopped_ev = 1'b0;
    trq_log = '0;
    wval = otl_pkg::eff_limit(pwdata[`OTL_TRQ_W-1:0], `OTL_TRQ_MAX);
    cval = pwdata[$bits(otl_pkg::otl_ctrl_t)-1:0];

    // a high input prohibits only its own direction
    fwd_ot = fwd_travel_ok_in & (q.ctrl.fwd_map != `OTL_MAP_IGNORE);
    rev_ot = rev_travel_ok_in & (q.ctrl.rev_map != `OTL_MAP_IGNORE);
    // logical forward is ccw for select 0 and cw for select 1
    mov_fwd = motor_ccw_in ^ q.ctrl.dir_sel;
    hit_f = fwd_ot & motor_moving_in & mov_fwd;
    hit_r = rev_ot & motor_moving_in & ~mov_fwd;
    stop_ot = q.stop_fwd ? fwd_ot : rev_ot;
    ref_away = q.stop_fwd ? torque_ref_in[`OTL_TRQ_W-1]
                          : (torque_ref_in > $signed(`OTL_TRQ_W'(0)));
    estop_mag = $signed(otl_pkg::eff_limit(q.estop_trq, q.max_trq));

    // stop sequence, re-evaluated every cycle
    case (q.st)
      otl_pkg::ST_RUN:
      begin
        trq_log = trq_lim;
        if (hit_f | hit_r)
        begin
          d.stop_fwd = hit_f;
          if (q.ctrl.trq_ctrl)
            d.st = otl_pkg::ST_SOFF;
          else if (q.ctrl.ot_mode == `OTL_OT_ZCLAMP || q.ctrl.ot_mode == `OTL_OT_COAST)
            d.st = otl_pkg::ST_DECEL;
          else
            d.st = otl_pkg::ST_SOFF;
        end
      end
      otl_pkg::ST_SOFF:
      begin
        // torque control always ends coasting, whatever the stop mode
        if (!motor_moving_in && q.ctrl.trq_ctrl)
        begin
          d.st = otl_pkg::ST_COAST;
          stopped_ev = 1'b1;
        end
        else if (!stop_ot)
          d.st = otl_pkg::ST_RUN;
      end
      otl_pkg::ST_DECEL:
      begin
        // braking torque opposes the stopped direction
        trq_log = q.stop_fwd ? -estop_mag : estop_mag;
        if (!motor_moving_in)
        begin
          stopped_ev = 1'b1;
          if (q.ctrl.ot_mode == `OTL_OT_ZCLAMP)
            d.st = otl_pkg::ST_ZCLAMP;
          else
            d.st = otl_pkg::ST_COAST;
        end
      end
      otl_pkg::ST_ZCLAMP, otl_pkg::ST_COAST:
      begin
        // a command away from the switch is still allowed
        if (!stop_ot || ref_away)
          d.st = otl_pkg::ST_RUN;
      end
      default:
      begin
        d.st = otl_pkg::ST_RUN;
      end
    endcase

    // the motor sees physical direction, so cw-forward inverts the sign
    d.trq = q.ctrl.dir_sel ? -trq_log : trq_log;
    d.fwd_ok = ~fwd_ot;
    d.rev_ok = ~rev_ot;
    d.clt = clt_next;
    for (int i = 0; i < `OTL_TERM_N; i++)
    begin
      // select 0 leaves every terminal off
      d.term[i] = clt_next && (q.ctrl.clt_sel == 2'(i + 1));
    end

    // apb: one wait cycle, read data is registered on the same edge that raises pready
    acc = psel & penable;
    wr = acc & q.ready & pwrite & ~q.slverr;
    d.ready = acc & ~q.ready;
    d.slverr = 1'b0;
    d.rdata = '0;
    if (acc && !q.ready)
    begin
      case (paddr)
        `OTL_A_CTRL: d.rdata = 32'(q.ctrl);
        `OTL_A_FWD_CAP: d.rdata = 32'(q.fwd_cap);
        `OTL_A_REV_CAP: d.rdata = 32'(q.rev_cap);
        `OTL_A_ESTOP: d.rdata = 32'(q.estop_trq);
        `OTL_A_MAX_TRQ: d.rdata = 32'(q.max_trq);
        `OTL_A_MONITOR: d.rdata = 32'({q.st, q.term, q.clt, q.rev_ok, q.fwd_ok});
        `OTL_A_IRQ_STAT: d.rdata = 32'(q.irq_stat);
        `OTL_A_IRQ_MASK: d.rdata = 32'(q.irq_mask);
        default: d.slverr = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        `OTL_A_CTRL: d.ctrl = otl_pkg::otl_ctrl_t'(cval);
        `OTL_A_FWD_CAP: d.fwd_cap = wval;
        `OTL_A_REV_CAP: d.rev_cap = wval;
        `OTL_A_ESTOP: d.estop_trq = pwdata[`OTL_TRQ_W-1:0];
        `OTL_A_MAX_TRQ: d.max_trq = wval;
        `OTL_A_IRQ_STAT: clr = pwdata[`OTL_IRQ_W-1:0];
        `OTL_A_IRQ_MASK: d.irq_mask = pwdata[`OTL_IRQ_W-1:0];
        default: d.slverr = 1'b0;
      endcase
    end

    // events: set wins over a simultaneous write-one clear
    ev[`OTL_IRQ_FWD_HIT] = hit_f & (q.st == otl_pkg::ST_RUN);
    ev[`OTL_IRQ_REV_HIT] = hit_r & (q.st == otl_pkg::ST_RUN);
    ev[`OTL_IRQ_CLT] = clt_next & ~q.clt;
    ev[`OTL_IRQ_STOPPED] = stopped_ev;
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q.ctrl <= otl_pkg::otl_ctrl_t'(`OTL_CTRL_RST);
      q.fwd_cap <= `OTL_TRQ_RST;
      q.rev_cap <= `OTL_TRQ_RST;
      q.estop_trq <= `OTL_TRQ_RST;
      q.max_trq <= `OTL_MAX_TRQ_RST;
      q.irq_stat <= '0;
      q.irq_mask <= `OTL_IRQ_MASK_RST;
      q.st <= otl_pkg::ST_RUN;
      q.stop_fwd <= 1'b0;
      q.fwd_ok <= 1'b0;
      q.rev_ok <= 1'b0;
      q.clt <= 1'b0;
      q.trq <= '0;
      q.term <= '0;
      q.irq <= 1'b0;
      q.rdata <= '0;
      q.ready <= 1'b0;
      q.slverr <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slverr;
  assign motor_torque = q.trq;
  assign servo_off_stop = (q.st == otl_pkg::ST_SOFF);
  assign servo_off_mode = q.ctrl.soff_mode;
  assign zero_clamp = (q.st == otl_pkg::ST_ZCLAMP);
  assign coast = (q.st == otl_pkg::ST_COAST);
  assign drive_state = q.st;
  assign torque_limited_out = q.clt;
  assign output_terminal_1 = q.term[0];
  assign output_terminal_2 = q.term[1];
  assign output_terminal_3 = q.term[2];
  assign irq = q.irq;

endmodule : otl_top

// ### logic/otl_torque_clamp.sv
// direction-dependent torque clamp and limit flag
`timescale 1ns/1ns
`include "otl_params.svh"
module otl_torque_clamp (
  input wire logic signed [`OTL_TRQ_W-1:0] torque_ref, // logical torque, % rated
  input wire logic [`OTL_TRQ_W-1:0] fwd_cap, // forward cap setting
  input wire logic [`OTL_TRQ_W-1:0] rev_cap, // reverse cap setting
  input wire logic [`OTL_TRQ_W-1:0] max_trq, // motor maximum torque
  input wire logic fwd_block, // forward torque prohibited
  input wire logic rev_block, // reverse torque prohibited
  input wire logic clt_now, // present limit flag
  output logic signed [`OTL_TRQ_W-1:0] torque_lim, // clamped logical torque
  output logic clt_next // next limit flag
);

  logic pos;
  logic blocked;
  logic over;
  logic under;
  logic [`OTL_TRQ_W:0] mag;
  logic [`OTL_TRQ_W:0] lim;
  logic [`OTL_TRQ_W:0] out_mag;
  logic [`OTL_TRQ_W:0] neg_mag;

  always_comb
  begin
    pos = ~torque_ref[`OTL_TRQ_W-1];
    mag = pos ? {torque_ref[`OTL_TRQ_W-1], torque_ref}
              : (`OTL_TRQ_W+1)'(-$signed({torque_ref[`OTL_TRQ_W-1], torque_ref}));
    // effective caps never exceed the motor maximum
    lim = pos ? {1'b0, otl_pkg::eff_limit(fwd_cap, max_trq)}
              : {1'b0, otl_pkg::eff_limit(rev_cap, max_trq)};
    blocked = pos ? fwd_block : rev_block;
    over = mag > lim;
    under = mag < lim;
    // equal holds the flag, so a reference parked on the cap does not chatter
    clt_next = over ? 1'b1 : (under ? 1'b0 : clt_now);
    out_mag = blocked ? '0 : (over ? lim : mag);
    neg_mag = (`OTL_TRQ_W+1)'(-$signed(out_mag));
    torque_lim = pos ? out_mag[`OTL_TRQ_W-1:0] : neg_mag[`OTL_TRQ_W-1:0];
  end

endmodule : otl_torque_clamp

// ### sim/otl_motion_model.sv
// limit switches and load motion as the block sees them
`timescale 1ns/1ns
module otl_motion_model #(parameter int SETTLE = 4) (
  input wire logic pclk, // clock
  input wire logic fwd_hit, // forward limit reached
  input wire logic rev_hit, // reverse limit reached
  input wire logic run_cmd, // host commands motion
  input wire logic ccw_cmd, // commanded sense
  output logic fwd_travel_ok_in, // high at limit
  output logic rev_travel_ok_in, // high at limit
  output logic motor_moving_in, // not at rest
  output logic motor_ccw_in // sense, ccw from load
);
  int left_q = 0;
  // switch contact opens at the limit, input pulled high
  assign fwd_travel_ok_in = fwd_hit;
  assign rev_travel_ok_in = rev_hit;
  assign motor_ccw_in = ccw_cmd;
  // load runs on after the command drops, so a stop is never instant
  always_ff @(posedge pclk) left_q <= run_cmd ? SETTLE : (left_q > 0 ? left_q - 1 : 0);
  assign motor_moving_in = run_cmd || left_q > 0;
endmodule : otl_motion_model

// ### sim/otl_top_checker.sv
// port assertions of the overtravel and torque-limit top
`timescale 1ns/1ns
module otl_top_checker (
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic motor_moving_in, // not at rest
  input wire logic [2:0] drive_state, // stop state
  input wire logic torque_limited_out, // limit flag
  input wire logic output_terminal_1, // terminal one
  input wire logic output_terminal_2, // terminal two
  input wire logic output_terminal_3 // terminal three
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_next_a: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after wait");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  term_onehot_a: assert property (
    $onehot0({output_terminal_3, output_terminal_2, output_terminal_1}))
    else $error("two terminals on");
  term_flag_a: assert property (
    output_terminal_1 || output_terminal_2 || output_terminal_3 |-> torque_limited_out)
    else $error("terminal on without limit");
  decel_hold_a: assert property (
    drive_state == 3'd2 && motor_moving_in |=> drive_state == 3'd2)
    else $error("decel left while moving");
  decel_end_a: assert property (
    drive_state == 3'd2 && !motor_moving_in |=> drive_state inside {3'd3, 3'd4})
    else $error("decel not ended at rest");
endmodule : otl_top_checker
bind otl_top otl_top_checker u_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .motor_moving_in, .drive_state, .torque_limited_out, .output_terminal_1,
  .output_terminal_2, .output_terminal_3);

// ### sim/tb_top.sv
// self-checking bench of the overtravel and torque-limit block
`timescale 1ns/1ns
`include "otl_params.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic fwd_hit = 1'b0, rev_hit = 1'b0, run_cmd = 1'b0, ccw_cmd = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic signed [`OTL_TRQ_W-1:0] torque_ref_in = 12'h000;
  logic signed [`OTL_TRQ_W-1:0] motor_torque;
  logic [31:0] prdata, rd_q;
  logic [2:0] drive_state, terms;
  logic [1:0] servo_off_mode;
  logic pready, pslverr, err_q, servo_off_stop, zero_clamp, coast, irq;
  logic torque_limited_out, output_terminal_1, output_terminal_2, output_terminal_3;
  logic fwd_travel_ok_in, rev_travel_ok_in, motor_moving_in, motor_ccw_in;
  int mismatches = 0, total_checks = 0;
  always #5 pclk = ~pclk;
  assign terms = {output_terminal_3, output_terminal_2, output_terminal_1};
  otl_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fwd_travel_ok_in, .rev_travel_ok_in, .torque_ref_in, .motor_moving_in,
    .motor_ccw_in, .motor_torque, .servo_off_stop, .servo_off_mode, .zero_clamp, .coast,
    .drive_state, .torque_limited_out, .output_terminal_1, .output_terminal_2,
    .output_terminal_3, .irq);
  otl_motion_model #(.SETTLE(4)) model (.pclk, .fwd_hit, .rev_hit, .run_cmd, .ccw_cmd,
    .fwd_travel_ok_in, .rev_travel_ok_in, .motor_moving_in, .motor_ccw_in);
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // idle edge at the end keeps a following setup off the release edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic trq(input logic [11:0] e);
    tick(3);
    `CHK("torque", e, motor_torque)
  endtask : trq
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  initial
  begin
    tick(16);
    presetn <= 1'b1;
    tick(1);
    apb(1'b0, `OTL_A_CTRL, 32'h0000_0000);
    `CHK("ctrl", 32'h0000_0C80, rd_q)
    apb(1'b0, `OTL_A_FWD_CAP, 32'h0000_0000);
    `CHK("cap", 32'h0000_0320, rd_q)
    apb(1'b0, 8'h20, 32'h0000_0000);
    `CHK("err", 1'b1, err_q)
    `CHK("soff_mode", 2'b00, servo_off_mode)
    $display("reset test done");
    torque_ref_in <= 12'h0C8;
    trq(12'h0C8);
    `CHK("clt", 1'b0, torque_limited_out)
    torque_ref_in <= 12'h1F4;
    trq(12'h12C);
    `CHK("clt", 1'b1, torque_limited_out)
    apb(1'b0, `OTL_A_MONITOR, 32'h0000_0000);
    `CHK("monitor", 32'h0000_0007, rd_q)
    apb(1'b1, `OTL_A_FWD_CAP, 32'h0000_0064);
    trq(12'h064);
    apb(1'b1, `OTL_A_CTRL, 32'h0000_0C81);
    trq(12'hF9C);
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, `OTL_A_CTRL, 32'h0000_0C80 | 32'(s << 14));
      tick(3);
      `CHK("term", s ? 3'(1 << (s - 1)) : 3'b000, terms)
    end
    $display("torque test done");
    apb(1'b1, `OTL_A_FWD_CAP, 32'h0000_0320);
    torque_ref_in <= 12'h0C8;
    fwd_hit <= 1'b1;
    trq(12'h000);
    torque_ref_in <= 12'hF38;
    trq(12'hF38);
    torque_ref_in <= 12'h0C8;
    apb(1'b1, `OTL_A_CTRL, 32'h0000_0E00);
    trq(12'h0C8);
    fwd_hit <= 1'b0;
    rev_hit <= 1'b1;
    torque_ref_in <= 12'hF38;
    apb(1'b1, `OTL_A_CTRL, 32'h0000_0C80);
    trq(12'h000);
    apb(1'b1, `OTL_A_CTRL, 32'h0000_2080);
    trq(12'hF38);
    rev_hit <= 1'b0;
    `CHK("irq", 1'b0, irq)
    apb(1'b1, `OTL_A_IRQ_MASK, 32'h0000_0008);
    $display("overtravel test done");
    // reference toward the switch, else a held stop would be left at once
    torque_ref_in <= 12'h064;
    apb(1'b1, `OTL_A_ESTOP, 32'h0000_0064);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, `OTL_A_CTRL, (m == 3) ? 32'h0000_0CA2 : 32'h0000_0C80 | 32'(m << 1));
      run_cmd <= 1'b1;
      ccw_cmd <= 1'b1;
      tick(3);
      fwd_hit <= 1'b1;
      tick(3);
      `CHK("state", (m % 3) ? 3'd2 : 3'd1, drive_state)
      `CHK("soff", (m % 3) == 0, servo_off_stop)
      if (m % 3)
        `CHK("torque", 12'hF9C, motor_torque)
      run_cmd <= 1'b0;
      tick(8);
      `CHK("state", m ? ((m == 1) ? 3'd3 : 3'd4) : 3'd1, drive_state)
      `CHK("zclamp", m == 1, zero_clamp)
      `CHK("coast", m >= 2, coast)
      `CHK("irq", m != 0, irq)
      fwd_hit <= 1'b0;
      apb(1'b1, `OTL_A_IRQ_STAT, 32'h0000_000F);
      tick(1);
      `CHK("irq", 1'b0, irq)
      `CHK("state", 3'd0, drive_state)
    end
    $display("stop test done");
    results();
  end
  initial
  begin
    tick(3000);
    mismatches++;
    results();
  end
endmodule : tb_top
